// >>> rfs_regs.svh
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH
// Functional notes
// - Drop received packets unless hop channel and vendor tag both match.
// - Addressed receiver accepts only packets addressed to it as global or local.
// - Sender marks each packet global or local from dest_addr and addr_mask.
// - Broadcast operation, the default, passes every received packet with matching hop channel and vendor tag to the host.
// - Addressed operation forwards matching data to host, drops the rest.
// - Streaming uses retry_count zero; no acknowledgements sent or expected.
// - Byte trigger and gap timeout gate only the first packet of an event.
// - Event runs until input empty or stream_byte_limit; packets hold max_packet_bytes.
// - Stream limit reached forces random 1..delay_slot_range slots, or one slot.
// - Streaming follow-on packets carry no radio initializer.
// - After an event ending below stream_byte_limit the sender stays silent exactly delay_slot_range slots.
// - Receivers back off random 0..delay_slot_range-1 slots after an event.
// - Multi-transmit sends each packet extra_tx_count+1 times back to back.
// - No reception between repeats; every repeat starts with an initializer.
// - forced_sync has no effect in multi-transmit mode.
// - Pending data checked at packet end; follow-on waits for all repeats.
// - Repeated packets count once toward stream_byte_limit.
// - Receiver of multi-transmit packet holds off event time plus random slots.
// - Follow-on multi-transmit expected: retune to next hop and listen bounded.
// - dest_addr all ones is global, delivered by every module.

`define RFS_OFF_CTRL     8'h00
`define RFS_OFF_ADDR     8'h04
`define RFS_OFF_DEST     8'h08
`define RFS_OFF_NET      8'h0C
`define RFS_OFF_SIZE     8'h10
`define RFS_OFF_TRIG     8'h14
`define RFS_OFF_SCHED    8'h18
`define RFS_OFF_STATUS   8'h1C

`define RFS_LO           0
`define RFS_MID          8
`define RFS_HI           16
`define RFS_CTRL_ADDRD   0
`define RFS_CTRL_MULTI   1
`define RFS_CTRL_FSYNC   2
`define RFS_CTRL_RR      4
`define RFS_STAT_HOLD    4
`define RFS_STAT_ACC     5

`define RFS_RESP_OKAY    2'h0
`define RFS_RESP_SLVERR  2'h2
`define RFS_GLOBAL_ADDR  12'hFFF

`define RFS_RST_SRC      12'h000
`define RFS_RST_MASK     12'hFFF
`define RFS_RST_DEST     12'hFFF
`define RFS_RST_HOP      8'h00
`define RFS_RST_VENDOR   16'h0000
`define RFS_RST_PKT      12'h040
`define RFS_RST_TT       16'hFFFF
`define RFS_RST_RB       12'h001
`define RFS_RST_RO       8'h03
`define RFS_RST_RN       8'h00
`define RFS_RST_MT       8'h00
`define RFS_RST_RR       4'h0
`define RFS_LFSR_SEED    16'hACE1
`endif

// >>> rfs_pkg.sv
package rfs_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_SEND} rfs_fsm_t;

    typedef struct packed {
        logic        addressed;
        logic        multi;
        logic        fsync;
        logic [3:0]  retry;
        logic [11:0] src;
        logic [11:0] mask;
        logic [11:0] dest;
        logic [7:0]  hop;
        logic [15:0] vendor;
        logic [11:0] max_pkt;
        logic [15:0] tt;
        logic [11:0] rb;
        logic [7:0]  ro;
        logic [7:0]  rn;
        logic [7:0]  mt;
    } rfs_cfg_t;

    typedef struct packed {
        logic [7:0]  hop;
        logic [15:0] vendor;
        logic [11:0] dest;
        logic        multi;
        logic        more;
        logic [7:0]  copies;
        logic [11:0] len;
    } rfs_rx_hdr_t;

    typedef struct packed {
        logic        sop;
        logic        eop;
        logic        init;
        logic        global;
        logic [11:0] dest;
        logic [7:0]  data;
    } rfs_tx_beat_t;

    typedef struct packed {
        rfs_fsm_t     st;
        rfs_cfg_t     cfg;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   waddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic         first;
        logic [11:0]  cnt;
        logic [11:0]  idx;
        logic [7:0]   copies;
        logic [15:0]  ev_bytes;
        logic [19:0]  gap_c;
        logic         tt_hit;
        logic [31:0]  hold_cyc;
        logic [7:0]   slots;
        logic [15:0]  slot_t;
        logic [15:0]  lfsr;
        logic         hit;
        logic         acc;
        logic         hdr_multi;
        logic         hdr_more;
        logic         out_valid;
        logic [7:0]   out_data;
        logic [15:0]  listen;
        logic         hop_adv;
        logic         tx_valid;
        rfs_tx_beat_t tx;
    } rfs_state_t;
endpackage : rfs_pkg

// >>> rfs_addr_filter_tx_scheduler.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rfs_regs.svh"

module rfs_addr_filter_tx_scheduler
    import rfs_pkg::*;
#(
    parameter int BUF_DEPTH     = 2048,
    parameter int SLOT_CYCLES   = 400,
    parameter int BYTE_CYCLES   = 40,
    parameter int GAP_UNIT      = 40,
    parameter int LISTEN_CYCLES = 4000
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Host serial input bytes
    input  wire logic         in_valid,
    input  wire logic [7:0]   in_data,
    output logic              in_ready,
    // Host serial output bytes
    output logic              out_valid,
    output logic [7:0]        out_data,
    input  wire logic         out_ready,
    // Radio transmit beats
    output logic              tx_valid,
    output rfs_tx_beat_t      tx_beat,
    input  wire logic         tx_ready,
    // Radio receive side
    input  wire logic         rx_hdr_valid,
    input  wire rfs_rx_hdr_t  rx_hdr,
    input  wire logic         rx_byte_valid,
    input  wire logic [7:0]   rx_byte,
    input  wire logic         rx_end,
    // Radio control
    output logic              rx_enable,
    output logic              ack_enable,
    output logic              forced_sync_en,
    output logic [7:0]        hop_channel_sel,
    output logic              hop_advance,
    output logic              listen_active,
    output logic              tx_inhibit
);
    localparam int          AW      = $clog2(BUF_DEPTH);
    localparam logic [11:0] DEPTH12 = 12'(BUF_DEPTH);
    localparam logic [15:0] SLOT_LD = 16'(SLOT_CYCLES - 1);

    localparam rfs_cfg_t CFG_RST = '{
        addressed: 1'b0, multi: 1'b0, fsync: 1'b0, retry: `RFS_RST_RR,
        src: `RFS_RST_SRC, mask: `RFS_RST_MASK, dest: `RFS_RST_DEST,
        hop: `RFS_RST_HOP, vendor: `RFS_RST_VENDOR, max_pkt: `RFS_RST_PKT,
        tt: `RFS_RST_TT, rb: `RFS_RST_RB, ro: `RFS_RST_RO, rn: `RFS_RST_RN,
        mt: `RFS_RST_MT};

    rfs_state_t  r;
    rfs_state_t  n;
    logic [7:0]  mem [BUF_DEPTH];
    logic        mem_we;
    logic [AW-1:0] rd_addr;
    logic [7:0]  rd_byte;
    logic [11:0] pkt_max;
    logic        tt_on;
    logic        gap_exp;
    logic        fill_done;
    logic        busy_hold;
    logic        hv_ok;
    logic        addr_ok;
    logic        tx_glob;
    logic [31:0] wimg;

    function automatic logic [31:0] reg_img(input rfs_state_t s, input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        if (a == `RFS_OFF_CTRL) begin
            v[`RFS_CTRL_ADDRD]     = s.cfg.addressed;
            v[`RFS_CTRL_MULTI]     = s.cfg.multi;
            v[`RFS_CTRL_FSYNC]     = s.cfg.fsync;
            v[`RFS_CTRL_RR +: 4]   = s.cfg.retry;
        end else if (a == `RFS_OFF_ADDR) begin
            v[`RFS_LO +: 12]       = s.cfg.src;
            v[`RFS_HI +: 12]       = s.cfg.mask;
        end else if (a == `RFS_OFF_DEST) begin
            v[`RFS_LO +: 12]       = s.cfg.dest;
        end else if (a == `RFS_OFF_NET) begin
            v[`RFS_LO +: 8]        = s.cfg.hop;
            v[`RFS_HI +: 16]       = s.cfg.vendor;
        end else if (a == `RFS_OFF_SIZE) begin
            v[`RFS_LO +: 12]       = s.cfg.max_pkt;
            v[`RFS_HI +: 16]       = s.cfg.tt;
        end else if (a == `RFS_OFF_TRIG) begin
            v[`RFS_LO +: 12]       = s.cfg.rb;
            v[`RFS_HI +: 8]        = s.cfg.ro;
        end else if (a == `RFS_OFF_SCHED) begin
            v[`RFS_LO +: 8]        = s.cfg.rn;
            v[`RFS_MID +: 8]       = s.cfg.mt;
        end else if (a == `RFS_OFF_STATUS) begin
            v[`RFS_LO +: 2]        = s.st;
            v[`RFS_STAT_HOLD]      = (s.hold_cyc != '0) || (s.slots != '0);
            v[`RFS_STAT_ACC]       = s.acc;
            v[`RFS_HI +: 16]       = s.ev_bytes;
        end
        return v;
    endfunction : reg_img

    function automatic logic known(input logic [7:0] a);
        return (a == `RFS_OFF_CTRL) || (a == `RFS_OFF_ADDR) || (a == `RFS_OFF_DEST)
            || (a == `RFS_OFF_NET) || (a == `RFS_OFF_SIZE) || (a == `RFS_OFF_TRIG)
            || (a == `RFS_OFF_SCHED) || (a == `RFS_OFF_STATUS);
    endfunction : known

    // Packet buffer, written from host input, read for every copy
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[r.cnt[AW-1:0]] <= in_data;
        end
    end
    assign rd_byte = mem[rd_addr];

    always_comb begin
        pkt_max = r.cfg.max_pkt;
        if (pkt_max == 12'h000) begin
            pkt_max = 12'h001;
        end else if (pkt_max > DEPTH12) begin
            pkt_max = DEPTH12;
        end
        tt_on     = r.cfg.tt != 16'h0000;
        gap_exp   = r.gap_c >= 20'(r.cfg.ro * GAP_UNIT);
        busy_hold = (r.hold_cyc != '0) || (r.slots != '0);
        // First packet waits for trigger or gap, later ones only for data
        fill_done = (r.st == ST_FILL) && (r.cnt != 12'h000)
            && ((r.cnt >= pkt_max) || (tt_on && r.ev_bytes >= r.cfg.tt)
            || (r.first ? (r.cnt >= r.cfg.rb || gap_exp) : !in_valid));
        in_ready  = (r.st == ST_FILL) && !fill_done;
        mem_we    = in_valid && in_ready;
        // Sender classification of its own destination
        tx_glob   = ((r.cfg.dest & r.cfg.mask) == r.cfg.mask)
            || (r.cfg.dest == `RFS_GLOBAL_ADDR);
        hv_ok     = (rx_hdr.hop == r.cfg.hop) && (rx_hdr.vendor == r.cfg.vendor);
        addr_ok   = ((rx_hdr.dest & r.cfg.mask) == (r.cfg.src & r.cfg.mask))
            || ((rx_hdr.dest & r.cfg.mask) == r.cfg.mask)
            || (rx_hdr.dest == `RFS_GLOBAL_ADDR);
        rd_addr   = '0;
        if (r.st == ST_SEND && !r.tx.eop) begin
            rd_addr = AW'(r.idx + 12'h001);
        end
        wimg = reg_img(r, r.waddr);
        for (int b = 0; b < 4; b++) begin
            if (r.wstrb[b]) begin
                wimg[b*8 +: 8] = r.wdata[b*8 +: 8];
            end
        end
    end

    always_comb begin
        n         = r;
        n.lfsr    = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
        n.hop_adv = 1'b0;

        // AXI write: address and data taken in either order
        if (s_axi_awvalid && !r.aw_got) begin
            n.aw_got = 1'b1;
            n.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = known(r.waddr) ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
            if (r.waddr == `RFS_OFF_CTRL) begin
                n.cfg.addressed = wimg[`RFS_CTRL_ADDRD];
                n.cfg.multi     = wimg[`RFS_CTRL_MULTI];
                n.cfg.fsync     = wimg[`RFS_CTRL_FSYNC];
                n.cfg.retry     = wimg[`RFS_CTRL_RR +: 4];
            end else if (r.waddr == `RFS_OFF_ADDR) begin
                n.cfg.src       = wimg[`RFS_LO +: 12];
                n.cfg.mask      = wimg[`RFS_HI +: 12];
            end else if (r.waddr == `RFS_OFF_DEST) begin
                n.cfg.dest      = wimg[`RFS_LO +: 12];
            end else if (r.waddr == `RFS_OFF_NET) begin
                n.cfg.hop       = wimg[`RFS_LO +: 8];
                n.cfg.vendor    = wimg[`RFS_HI +: 16];
            end else if (r.waddr == `RFS_OFF_SIZE) begin
                n.cfg.max_pkt   = wimg[`RFS_LO +: 12];
                n.cfg.tt        = wimg[`RFS_HI +: 16];
            end else if (r.waddr == `RFS_OFF_TRIG) begin
                n.cfg.rb        = wimg[`RFS_LO +: 12];
                n.cfg.ro        = wimg[`RFS_HI +: 8];
            end else if (r.waddr == `RFS_OFF_SCHED) begin
                n.cfg.rn        = wimg[`RFS_LO +: 8];
                n.cfg.mt        = wimg[`RFS_MID +: 8];
            end
        end

        // AXI read
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid) begin
            n.rvalid = 1'b1;
            n.rdata  = reg_img(r, s_axi_araddr);
            n.rresp  = known(s_axi_araddr) ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
        end

        // Hold-off: cycle count first, then delay slots
        if (r.hold_cyc != '0) begin
            n.hold_cyc = r.hold_cyc - 32'h0000_0001;
        end else if (r.slots != 8'h00) begin
            if (r.slot_t == 16'h0000) begin
                n.slots  = r.slots - 8'h01;
                n.slot_t = SLOT_LD;
            end else begin
                n.slot_t = r.slot_t - 16'h0001;
            end
        end

        // Transmit scheduler
        case (r.st)
            ST_IDLE: begin
                if (in_valid && !busy_hold && !rx_hdr_valid && !rx_end) begin
                    n.st       = ST_FILL;
                    n.first    = 1'b1;
                    n.cnt      = 12'h000;
                    n.ev_bytes = 16'h0000;
                    n.gap_c    = 20'h0_0000;
                end
            end
            ST_FILL: begin
                if (mem_we) begin
                    n.cnt      = r.cnt + 12'h001;
                    n.ev_bytes = r.ev_bytes + 16'h0001;
                    n.gap_c    = 20'h0_0000;
                end else if (!gap_exp) begin
                    n.gap_c    = r.gap_c + 20'h0_0001;
                end
                if (fill_done) begin
                    n.st          = ST_SEND;
                    n.idx         = 12'h000;
                    n.copies      = r.cfg.multi ? r.cfg.mt : 8'h00;
                    n.tt_hit      = tt_on && (r.ev_bytes >= r.cfg.tt);
                    n.tx_valid    = 1'b1;
                    n.tx.data     = rd_byte;
                    n.tx.sop      = 1'b1;
                    n.tx.eop      = r.cnt == 12'h001;
                    n.tx.init     = r.first || r.cfg.multi;
                    n.tx.global   = tx_glob;
                    n.tx.dest     = r.cfg.dest;
                end else if (!r.first && r.cnt == 12'h000 && !in_valid) begin
                    n.st     = ST_IDLE;
                    n.slots  = r.cfg.rn;
                    n.slot_t = SLOT_LD;
                end
            end
            ST_SEND: begin
                if (r.tx_valid && tx_ready) begin
                    if (!r.tx.eop) begin
                        n.idx     = r.idx + 12'h001;
                        n.tx.data = rd_byte;
                        n.tx.sop  = 1'b0;
                        n.tx.eop  = (r.idx + 12'h002) == r.cnt;
                    end else if (r.copies != 8'h00) begin
                        n.copies  = r.copies - 8'h01;
                        n.idx     = 12'h000;
                        n.tx.data = rd_byte;
                        n.tx.sop  = 1'b1;
                        n.tx.eop  = r.cnt == 12'h001;
                        n.tx.init = 1'b1;
                    end else begin
                        n.tx_valid = 1'b0;
                        n.slot_t   = SLOT_LD;
                        if (r.tt_hit) begin
                            n.st    = ST_IDLE;
                            n.slots = (r.cfg.rn == 8'h00) ? 8'h01
                                : 8'(r.lfsr % 16'(r.cfg.rn)) + 8'h01;
                        end else if (in_valid) begin
                            n.st    = ST_FILL;
                            n.first = 1'b0;
                            n.cnt   = 12'h000;
                            n.gap_c = 20'h0_0000;
                        end else begin
                            n.st    = ST_IDLE;
                            n.slots = r.cfg.rn;
                        end
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // Receive filter, ignored while sending and between repeats
        if (r.out_valid && out_ready) begin
            n.out_valid = 1'b0;
        end
        if (r.listen != 16'h0000) begin
            n.listen = r.listen - 16'h0001;
        end
        if (r.st != ST_SEND) begin
            if (rx_hdr_valid) begin
                n.hit       = hv_ok;
                n.acc       = hv_ok && (!r.cfg.addressed || addr_ok);
                n.hdr_multi = rx_hdr.multi;
                n.hdr_more  = rx_hdr.more;
                n.listen    = 16'h0000;
                if (hv_ok && rx_hdr.multi && r.st == ST_IDLE) begin
                    n.hold_cyc = 32'(rx_hdr.copies * rx_hdr.len * BYTE_CYCLES);
                    n.slots    = (r.cfg.rn == 8'h00) ? 8'h00
                        : 8'(r.lfsr % 16'(r.cfg.rn));
                    n.slot_t   = SLOT_LD;
                end
            end
            if (rx_byte_valid && r.acc && !(r.out_valid && !out_ready)) begin
                n.out_valid = 1'b1;
                n.out_data  = rx_byte;
            end
            if (rx_end) begin
                n.acc = 1'b0;
                if (r.hit && r.hdr_multi && r.hdr_more) begin
                    n.hop_adv = 1'b1;
                    n.listen  = 16'(LISTEN_CYCLES);
                end else if (r.hit && !r.hdr_multi && !r.hdr_more
                        && r.st == ST_IDLE && r.cfg.rn != 8'h00) begin
                    n.slots  = 8'(r.lfsr % 16'(r.cfg.rn));
                    n.slot_t = SLOT_LD;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r      <= '0;
            r.st   <= ST_IDLE;
            r.cfg  <= CFG_RST;
            r.lfsr <= `RFS_LFSR_SEED;
        end else begin
            r <= n;
        end
    end

    assign s_axi_awready   = !r.aw_got;
    assign s_axi_wready    = !r.w_got;
    assign s_axi_bvalid    = r.bvalid;
    assign s_axi_bresp     = r.bresp;
    assign s_axi_arready   = !r.rvalid;
    assign s_axi_rvalid    = r.rvalid;
    assign s_axi_rdata     = r.rdata;
    assign s_axi_rresp     = r.rresp;
    assign out_valid       = r.out_valid;
    assign out_data        = r.out_data;
    assign tx_valid        = r.tx_valid;
    assign tx_beat         = r.tx;
    assign rx_enable       = r.st != ST_SEND;
    assign ack_enable      = r.cfg.retry != 4'h0;
    assign forced_sync_en  = r.cfg.fsync && !r.cfg.multi;
    assign hop_channel_sel = r.cfg.hop;
    assign hop_advance     = r.hop_adv;
    assign listen_active   = r.listen != 16'h0000;
    assign tx_inhibit      = busy_hold;
endmodule : rfs_addr_filter_tx_scheduler

// >>> rfs_asserts.sv
`timescale 1ns/100ps
module rfs_asserts
    import rfs_pkg::*;
(
    // Clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // Write channels
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic         s_axi_bvalid,
    // Streams
    input wire logic         in_ready,
    input wire logic         out_valid,
    input wire logic [7:0]   out_data,
    input wire logic         out_ready,
    input wire logic         tx_valid,
    input wire rfs_tx_beat_t tx_beat,
    input wire logic         tx_ready,
    // Radio control
    input wire logic         rx_enable,
    input wire logic         hop_advance,
    input wire logic         tx_inhibit
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence tx_stall;
        tx_valid && !tx_ready;
    endsequence
    chk_no_rx_send: assert property (tx_valid |-> !rx_enable)
        else $error("receiver open while sending");
    chk_beat_hold: assert property (tx_stall |=> tx_valid && $stable(tx_beat))
        else $error("tx beat changed while stalled");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("host byte changed while stalled");
    chk_fill_closed: assert property (tx_valid |-> !in_ready)
        else $error("input accepted while sending");
    chk_all_ones: assert property (tx_valid && tx_beat.dest == 12'hFFF |-> tx_beat.global)
        else $error("all ones destination not global");
    chk_hop_pulse: assert property ($rose(hop_advance) |=> !hop_advance)
        else $error("hop advance longer than one cycle");
    chk_hold_quiet: assert property (tx_inhibit |-> !tx_valid)
        else $error("sending during hold-off");
    chk_wr_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
endmodule : rfs_asserts

bind rfs_addr_filter_tx_scheduler rfs_asserts u_rfs_asserts (.*);

// >>> rfs_peer_model.sv
`timescale 1ns/100ps
module rfs_peer_model
    import rfs_pkg::*;
(
    input wire logic         aclk,
    input wire logic         tx_valid,
    input wire rfs_tx_beat_t tx_beat,
    output logic             tx_ready,
    output logic             rx_hdr_valid,
    output rfs_rx_hdr_t      rx_hdr,
    output logic             rx_byte_valid,
    output logic [7:0]       rx_byte,
    output logic             rx_end
);
    logic         slow = 1'b0;
    rfs_tx_beat_t beats[$];
    initial begin
        tx_ready = 1'b0;
        rx_hdr_valid = 1'b0;
        rx_hdr = '0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_end = 1'b0;
    end
    // Slow mode drops tx_ready every other cycle
    always @(posedge aclk) begin
        if (tx_valid && tx_ready) beats.push_back(tx_beat);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    task automatic rx_pkt(input logic [11:0] dest, input logic [7:0] d);
        @(posedge aclk);
        rx_hdr_valid <= 1'b1;
        rx_hdr <= '{8'h00, 16'h0000, dest, 1'b0, 1'b0, 8'h01, 12'h001};
        @(posedge aclk);
        rx_hdr_valid <= 1'b0;
        rx_hdr <= ~rx_hdr;
        rx_byte_valid <= 1'b1;
        rx_byte <= d;
        @(posedge aclk);
        rx_byte_valid <= 1'b0;
        rx_end <= 1'b1;
        rx_byte <= ~d;
        @(posedge aclk);
        rx_end <= 1'b0;
    endtask : rx_pkt
endmodule : rfs_peer_model

// >>> rfs_tb.sv
`timescale 1ns/100ps
`include "rfs_regs.svh"
module tb;
    import rfs_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, in_valid = 0, out_ready = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, in_data = 0, out_data, rx_byte, outq[$];
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready;
    logic out_valid, tx_valid, tx_ready, rx_hdr_valid, rx_byte_valid, rx_end, ack_enable, fs_en;
    rfs_tx_beat_t tx_beat;
    rfs_rx_hdr_t  rx_hdr;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    rfs_addr_filter_tx_scheduler #(.SLOT_CYCLES(4), .BYTE_CYCLES(2), .GAP_UNIT(2),
        .LISTEN_CYCLES(8)) dut (.*, .forced_sync_en(fs_en), .hop_channel_sel(), .hop_advance(),
        .listen_active(), .tx_inhibit(), .rx_enable());
    rfs_peer_model peer (.*);
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (out_valid && out_ready) outq.push_back(out_data);
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        cmp(32'(s_axi_bresp), 32'(er), "bresp");
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        cmp(s_axi_rdata, ex, "rdata");
        cmp(32'(s_axi_rresp), 32'(er), "rresp");
    endtask : axr
    task automatic host(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            in_valid <= 1;
            in_data <= b + 8'(i);
            do @(posedge aclk); while (!in_ready);
        end
        in_valid <= 0;
    endtask : host
    task automatic rx_chk(input logic [11:0] dest, input logic [7:0] d, input int acc);
        peer.rx_pkt(dest, d);
        repeat (4) @(posedge aclk);
        cmp(32'(outq.size()), 32'(acc), "host bytes");
        if (outq.size() > 0) cmp(32'(outq.pop_front()), 32'(d), "host data");
    endtask : rx_chk
    task automatic tx_chk(input logic [23:0] ex[$]);
        repeat (80) @(posedge aclk);
        cmp(32'(peer.beats.size()), 32'(ex.size()), "beat count");
        foreach (ex[i]) if (i < peer.beats.size()) cmp(32'(peer.beats[i]), 32'(ex[i]), "beat");
        peer.beats.delete();
    endtask : tx_chk
    task automatic end_sim;
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        axr(`RFS_OFF_DEST, 32'h0000_0FFF, 2'h0);
        axr(`RFS_OFF_SIZE, 32'hFFFF_0040, 2'h0);
        axr(8'h20, 32'h0000_0000, 2'h2);
        axw(8'h20, 32'h0000_0001, 2'h2);
        cmp(32'(ack_enable), 32'h0, "ack");
        $display("test registers done");
        rx_chk(12'h345, 8'hA5, 1);
        axw(`RFS_OFF_ADDR, 32'h0FF0_0012, 2'h0);
        axw(`RFS_OFF_CTRL, 32'h0000_0001, 2'h0);
        rx_chk(12'h345, 8'h11, 0);
        rx_chk(12'h01F, 8'h22, 1);
        rx_chk(12'hFFF, 8'h33, 1);
        $display("test receive filter done");
        axw(`RFS_OFF_CTRL, 32'h0000_0000, 2'h0);
        axw(`RFS_OFF_SIZE, 32'h0000_0002, 2'h0);
        axw(`RFS_OFF_TRIG, 32'h0003_0002, 2'h0);
        axw(`RFS_OFF_SCHED, 32'h0000_0002, 2'h0);
        peer.slow = 1;
        host(3, 8'h40);
        tx_chk('{24'hBF_FF40, 24'h7F_FF41, 24'hDF_FF42});
        $display("test streaming done");
        axw(`RFS_OFF_CTRL, 32'h0000_0006, 2'h0);
        axw(`RFS_OFF_SCHED, 32'h0000_0100, 2'h0);
        cmp(32'(fs_en), 32'h0, "forced sync");
        host(1, 8'h77);
        tx_chk('{24'hFF_FF77, 24'hFF_FF77});
        $display("test multi-transmit done");
        end_sim();
    end
endmodule : tb
